// file: logic/sfr_interrupt_enable_flags.v
// Special function register bank: system interrupt enables and cause flags.
`timescale 1ns/1ps
`include "sfr_consts.vh"

module sfr_interrupt_enable_flags (
  // Clock and resets
  input  wire                       ref_clk_in,
  input  wire                       rst_in,
  input  wire                       power_up_clear_in,
  // Peripheral bus
  input  wire [`SFR_ADDR_WIDTH-1:0] addr_in,
  input  wire                       read_in,
  input  wire                       write_in,
  input  wire [7:0]                 wdata_in,
  output wire [7:0]                 rdata_out,
  // Hardware events
  input  wire                       wdt_expire_in,
  input  wire                       wdt_key_violation_in,
  input  wire                       wdt_interval_mode_in,
  input  wire                       osc_fault_in,
  input  wire                       ext_reset_event_in,
  input  wire                       nmi_event_in,
  input  wire                       flash_violation_in,
  input  wire                       general_irq_enable_in,
  // Interrupt requests
  output wire                       wdt_irq_out,
  output wire                       nmi_vector_irq_out,
  output wire                       flash_violation_irq_out
);

  // --------------------------------------------------------------------
  // Event synchronisation
  // --------------------------------------------------------------------
  // Oscillator fault and pin events come from outside this clock domain.
  wire [2:0] pin_sync;

  sfr_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({nmi_event_in, ext_reset_event_in, osc_fault_in}),
    .sync_out   (pin_sync)
  );

  wire osc_fault_sync = pin_sync[0];
  wire ext_reset_sync = pin_sync[1];
  wire nmi_level_sync = pin_sync[2];

  // The NMI is an edge event; a held pin must not refire after a clear.
  reg nmi_prev_reg;
  reg ext_prev_reg;

  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      nmi_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      nmi_prev_reg <= nmi_level_sync;
      ext_prev_reg <= ext_reset_sync;
    end
  end

  wire nmi_rise = nmi_level_sync & ~nmi_prev_reg;
  wire ext_rise = ext_reset_sync & ~ext_prev_reg;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire wr_enable = write_in & (addr_in == `SFR_ENABLE_1_ADDR);
  wire wr_flag   = write_in & (addr_in == `SFR_FLAG_1_ADDR);

  // --------------------------------------------------------------------
  // Enable register
  // --------------------------------------------------------------------
  // Only four enable bits exist; no storage for the other positions.
  reg wdt_irq_enable_reg;
  reg osc_fault_irq_enable_reg;
  reg nmi_irq_enable_reg;
  reg flash_violation_irq_enable_reg;

  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wdt_irq_enable_reg             <= `SFR_EN_CLR_VALUE;
      osc_fault_irq_enable_reg       <= `SFR_EN_CLR_VALUE;
      nmi_irq_enable_reg             <= `SFR_EN_CLR_VALUE;
      flash_violation_irq_enable_reg <= `SFR_EN_CLR_VALUE;
    end
    else if (power_up_clear_in)
    begin
      wdt_irq_enable_reg             <= `SFR_EN_CLR_VALUE;
      osc_fault_irq_enable_reg       <= `SFR_EN_CLR_VALUE;
      nmi_irq_enable_reg             <= `SFR_EN_CLR_VALUE;
      flash_violation_irq_enable_reg <= `SFR_EN_CLR_VALUE;
    end
    else if (wr_enable)
    begin
      wdt_irq_enable_reg             <= wdata_in[`SFR_EN_WDT_BIT];
      osc_fault_irq_enable_reg       <= wdata_in[`SFR_EN_OSC_BIT];
      nmi_irq_enable_reg             <= wdata_in[`SFR_EN_NMI_BIT];
      flash_violation_irq_enable_reg <= wdata_in[`SFR_EN_ACCV_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Flag register
  // --------------------------------------------------------------------
  wire watchdog_flag;
  wire osc_fault_flag;
  wire power_on_flag;
  wire external_reset_flag;
  wire nmi_flag;

  // Power-on bits: only the asynchronous power-on reset restores them.
  sfr_flag_bit #(
    .RESET_VALUE (`SFR_WDT_POR_VALUE)
  ) u_watchdog_flag (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .clear_in   (1'b0),
    .write_in   (wr_flag),
    .wdata_in   (wdata_in[`SFR_FLG_WDT_BIT]),
    .set_in     (wdt_expire_in | wdt_key_violation_in),
    .flag_out   (watchdog_flag)
  );

  // No hardware event sets this after power-on; software may set or clear it.
  sfr_flag_bit #(
    .RESET_VALUE (`SFR_POR_POR_VALUE)
  ) u_power_on_flag (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .clear_in   (1'b0),
    .write_in   (wr_flag),
    .wdata_in   (wdata_in[`SFR_FLG_POR_BIT]),
    .set_in     (1'b0),
    .flag_out   (power_on_flag)
  );

  sfr_flag_bit #(
    .RESET_VALUE (`SFR_RST_POR_VALUE)
  ) u_external_reset_flag (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .clear_in   (1'b0),
    .write_in   (wr_flag),
    .wdata_in   (wdata_in[`SFR_FLG_RST_BIT]),
    .set_in     (ext_rise),
    .flag_out   (external_reset_flag)
  );

  // Power-up clear bits: restored by both resets.
  sfr_flag_bit #(
    .RESET_VALUE (`SFR_OSC_CLR_VALUE)
  ) u_osc_fault_flag (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .clear_in   (power_up_clear_in),
    .write_in   (wr_flag),
    .wdata_in   (wdata_in[`SFR_FLG_OSC_BIT]),
    .set_in     (osc_fault_sync),
    .flag_out   (osc_fault_flag)
  );

  sfr_flag_bit #(
    .RESET_VALUE (`SFR_NMI_CLR_VALUE)
  ) u_nmi_flag (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .clear_in   (power_up_clear_in),
    .write_in   (wr_flag),
    .wdata_in   (wdata_in[`SFR_FLG_NMI_BIT]),
    .set_in     (nmi_rise),
    .flag_out   (nmi_flag)
  );

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Absent bits and the two unpopulated bytes read as zero.
  reg [7:0] read_mux;
  reg [7:0] rdata_reg;

  always @*
  begin
    read_mux = 8'h00;
    case (addr_in)
      `SFR_ENABLE_1_ADDR:
      begin
        read_mux[`SFR_EN_WDT_BIT]  = wdt_irq_enable_reg;
        read_mux[`SFR_EN_OSC_BIT]  = osc_fault_irq_enable_reg;
        read_mux[`SFR_EN_NMI_BIT]  = nmi_irq_enable_reg;
        read_mux[`SFR_EN_ACCV_BIT] = flash_violation_irq_enable_reg;
      end
      `SFR_FLAG_1_ADDR:
      begin
        read_mux[`SFR_FLG_WDT_BIT] = watchdog_flag;
        read_mux[`SFR_FLG_OSC_BIT] = osc_fault_flag;
        read_mux[`SFR_FLG_POR_BIT] = power_on_flag;
        read_mux[`SFR_FLG_RST_BIT] = external_reset_flag;
        read_mux[`SFR_FLG_NMI_BIT] = nmi_flag;
      end
      default:
        read_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_reg <= 8'h00;
    else if (read_in)
      rdata_reg <= read_mux;
  end

  assign rdata_out = rdata_reg;

  // --------------------------------------------------------------------
  // Interrupt requests
  // --------------------------------------------------------------------
  // The watchdog enable counts only in interval timer mode.
  assign wdt_irq_out = watchdog_flag & wdt_irq_enable_reg
                     & wdt_interval_mode_in;

  // The general enable is deliberately not in these terms.
  assign nmi_vector_irq_out = (nmi_flag & nmi_irq_enable_reg)
                            | (osc_fault_flag & osc_fault_irq_enable_reg)
                            | (flash_violation_in
                               & flash_violation_irq_enable_reg);

  assign flash_violation_irq_out = flash_violation_in
                                 & flash_violation_irq_enable_reg;

endmodule // sfr_interrupt_enable_flags

// file: logic/sfr_consts.vh
// Offsets, field positions and reset values of the special function bank.
`ifndef SFR_CONSTS_VH
`define SFR_CONSTS_VH

// ----------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------
`define SFR_ADDR_WIDTH 4
`define SFR_ENABLE_1_ADDR 4'h0
`define SFR_ENABLE_2_ADDR 4'h1
`define SFR_FLAG_1_ADDR 4'h2
`define SFR_FLAG_2_ADDR 4'h3

// ----------------------------------------------------------------------
// Enable register fields
// ----------------------------------------------------------------------
`define SFR_EN_WDT_BIT 0
`define SFR_EN_OSC_BIT 1
`define SFR_EN_NMI_BIT 4
`define SFR_EN_ACCV_BIT 5

// ----------------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------------
`define SFR_FLG_WDT_BIT 0
`define SFR_FLG_OSC_BIT 1
`define SFR_FLG_POR_BIT 2
`define SFR_FLG_RST_BIT 3
`define SFR_FLG_NMI_BIT 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SFR_EN_CLR_VALUE 1'h0
`define SFR_OSC_CLR_VALUE 1'h1
`define SFR_NMI_CLR_VALUE 1'h0
`define SFR_WDT_POR_VALUE 1'h0
`define SFR_POR_POR_VALUE 1'h1
`define SFR_RST_POR_VALUE 1'h0

`endif

// file: logic/sfr_flag_bit.v
// One hardware-set, software-written flag bit with a selectable clearing reset.
`timescale 1ns/1ps
module sfr_flag_bit #(
  parameter RESET_VALUE = 1'b0
) (
  // Clock and resets
  input  wire ref_clk_in,
  input  wire rst_in,
  input  wire clear_in,
  // Software write
  input  wire write_in,
  input  wire wdata_in,
  // Hardware event
  input  wire set_in,
  // State
  output wire flag_out
);

  reg flag_reg;
  reg flag_next;

  // Set wins over a software write of zero in the same cycle.
  always @*
  begin
    flag_next = flag_reg;
    if (write_in)
      flag_next = wdata_in;
    if (set_in)
      flag_next = 1'b1;
  end

  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      flag_reg <= RESET_VALUE;
    else if (clear_in)
      flag_reg <= RESET_VALUE;
    else
      flag_reg <= flag_next;
  end

  assign flag_out = flag_reg;

endmodule // sfr_flag_bit

// file: logic/sfr_sync.v
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module sfr_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             ref_clk_in,
  input  wire             rst_in,
  // Levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule // sfr_sync

// file: test/core_bus_model.sv
// Processor core side of the peripheral bus: byte reads and writes.
`timescale 1ns/1ps
module core_bus_model (
  input  wire       ref_clk_in,
  output reg  [3:0] addr_out,
  output reg        read_out,
  output reg        write_out,
  output reg  [7:0] wdata_out,
  input  wire [7:0] rdata_in
);
  // ------------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------------
  // Called just after a rising edge; each strobe stands for one cycle.
  // An idle edge ends every call, so a following call never reassigns
  // a strobe in the time step in which it was just lowered.
  initial
  begin
    addr_out = 4'hF;
    read_out = 1'b0;
    write_out = 1'b0;
    wdata_out = 8'h00;
  end
  task wr(input [3:0] a, input [7:0] d);
    write_out <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge ref_clk_in);
    write_out <= 1'b0;
    // Released data is scrambled so a stale value never looks valid.
    wdata_out <= ~d;
    @(posedge ref_clk_in);
  endtask
  task rd(input [3:0] a, output [7:0] d);
    read_out <= 1'b1;
    addr_out <= a;
    @(posedge ref_clk_in);
    read_out <= 1'b0;
    @(posedge ref_clk_in);
    // No read at this edge, so the data captured one edge ago stands.
    d = rdata_in;
  endtask
endmodule // core_bus_model

// file: test/sfr_monitor.sv
// Concurrent checks on the special function bank ports.
`timescale 1ns/1ps
module sfr_monitor (
  input wire       ref_clk_in,
  input wire       rst_in,
  input wire       power_up_clear_in,
  input wire [3:0] addr_in,
  input wire       read_in,
  input wire       write_in,
  input wire [7:0] wdata_in,
  input wire [7:0] rdata_out,
  input wire       wdt_interval_mode_in,
  input wire       flash_violation_in,
  input wire       wdt_irq_out,
  input wire       nmi_vector_irq_out,
  input wire       flash_violation_irq_out
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_en_write;
    write_in && addr_in == 4'h0 && !power_up_clear_in;
  endsequence
  sequence s_en_idle;
    !write_in && !power_up_clear_in;
  endsequence
  sequence s_en_read;
    read_in && !write_in && addr_in == 4'h0 && !power_up_clear_in;
  endsequence
  a_enable_readback: assert property (
    s_en_write ##1 s_en_idle ##1 s_en_read |=>
    rdata_out == ($past(wdata_in, 3) & 8'h33)) else $error("enable readback");
  a_enable_unused_zero: assert property (
    read_in && addr_in == 4'h0 |=> (rdata_out & 8'hCC) == 8'h00)
    else $error("enable spare bits set");
  a_flag_unused_zero: assert property (
    read_in && addr_in == 4'h2 |=> (rdata_out & 8'hE0) == 8'h00)
    else $error("flag spare bits set");
  a_empty_reads_zero: assert property (
    read_in && addr_in[0] |=> rdata_out == 8'h00)
    else $error("empty address read nonzero");
  a_rdata_stands: assert property (!read_in |=> $stable(rdata_out))
    else $error("read data moved without a read");
  a_clear_disables: assert property (
    power_up_clear_in |=> !wdt_irq_out && !nmi_vector_irq_out
    && !flash_violation_irq_out) else $error("request after power-up clear");
  a_enable_off_quiet: assert property (
    s_en_write ##0 (wdata_in == 8'h00) |=> !wdt_irq_out && !nmi_vector_irq_out)
    else $error("request without enable");
  a_wdt_mode_gate: assert property (
    wdt_irq_out |-> wdt_interval_mode_in)
    else $error("watchdog request outside interval mode");
  a_flash_cause: assert property (
    flash_violation_irq_out |-> flash_violation_in && nmi_vector_irq_out)
    else $error("flash request");
endmodule // sfr_monitor

// file: test/testbench.sv
// Self-checking bench for the special function register bank.
`timescale 1ns/1ps
module testbench;
  reg        ref_clk_in = 1'b0;
  reg        rst_in = 1'b1;
  reg        pwr_clr = 1'b0;
  reg        wdt_exp = 1'b0;
  reg        wdt_key = 1'b0;
  reg        wdt_mode = 1'b0;
  reg        osc = 1'b0;
  reg        ext = 1'b0;
  reg        nmi = 1'b0;
  reg        flash = 1'b0;
  reg        gie = 1'b0;
  wire [3:0] addr;
  wire       rd_s;
  wire       wr_s;
  wire [7:0] wd;
  wire [7:0] rdata;
  wire       i_wdt;
  wire       i_nmi;
  wire       i_fl;
  wire [7:0] irqs = {5'h00, i_wdt, i_nmi, i_fl};
  integer    error_cnt = 0;
  integer    n_checks = 0;
  integer    cyc = 0;
  // ------------------------------------------------------------------
  // Structure and helpers
  // ------------------------------------------------------------------
  always #5 ref_clk_in = ~ref_clk_in;
  core_bus_model i_core (.ref_clk_in(ref_clk_in), .addr_out(addr),
    .read_out(rd_s), .write_out(wr_s), .wdata_out(wd), .rdata_in(rdata));
  sfr_interrupt_enable_flags i_dut (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .power_up_clear_in(pwr_clr), .addr_in(addr),
    .read_in(rd_s), .write_in(wr_s), .wdata_in(wd), .rdata_out(rdata),
    .wdt_expire_in(wdt_exp), .wdt_key_violation_in(wdt_key),
    .wdt_interval_mode_in(wdt_mode), .osc_fault_in(osc),
    .ext_reset_event_in(ext), .nmi_event_in(nmi),
    .flash_violation_in(flash), .general_irq_enable_in(gie),
    .wdt_irq_out(i_wdt), .nmi_vector_irq_out(i_nmi),
    .flash_violation_irq_out(i_fl));
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  task chk(input [7:0] got, input [7:0] exp, input [8*12-1:0] what);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch at %0t %0s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task rdc(input [3:0] a, input [7:0] exp);
    reg [7:0] d;
    i_core.rd(a, d);
    chk(d, exp, "read");
  endtask
  task irqc(input [7:0] exp);
    #1;
    chk(irqs, exp, "requests");
    @(posedge ref_clk_in);
  endtask
  task wait_sync;
    repeat (4) @(posedge ref_clk_in);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_reset;
    rdc(4'h0, 8'h00);
    rdc(4'h2, 8'h06);
    i_core.wr(4'h2, 8'h00);
    rdc(4'h2, 8'h00);
    $display("test reset done");
  endtask
  task t_access;
    i_core.wr(4'h0, 8'hFF);
    rdc(4'h0, 8'h33);
    i_core.wr(4'h1, 8'hFF);
    rdc(4'h1, 8'h00);
    i_core.wr(4'h3, 8'hFF);
    rdc(4'h3, 8'h00);
    rdc(4'hA, 8'h00);
    $display("test access done");
  endtask
  task t_events;
    i_core.wr(4'h0, 8'h00);
    i_core.wr(4'h2, 8'h00);
    wdt_key <= 1'b1;
    ext <= 1'b1;
    @(posedge ref_clk_in);
    wdt_key <= 1'b0;
    wait_sync;
    rdc(4'h2, 8'h09);
    ext <= 1'b0;
    $display("test events done");
  endtask
  task t_irq;
    i_core.wr(4'h2, 8'h00);
    i_core.wr(4'h0, 8'h33);
    irqc(8'h00);
    wdt_exp <= 1'b1;
    @(posedge ref_clk_in);
    wdt_exp <= 1'b0;
    irqc(8'h00);
    wdt_mode <= 1'b1;
    irqc(8'h04);
    nmi <= 1'b1;
    wait_sync;
    irqc(8'h06);
    nmi <= 1'b0;
    i_core.wr(4'h0, 8'h23);
    flash <= 1'b1;
    irqc(8'h07);
    flash <= 1'b0;
    i_core.wr(4'h0, 8'h02);
    osc <= 1'b1;
    wait_sync;
    irqc(8'h02);
    osc <= 1'b0;
    rdc(4'h2, 8'h13);
    $display("test irq done");
  endtask
  task t_pwr_clear;
    i_core.wr(4'h0, 8'h33);
    i_core.wr(4'h2, 8'h1D);
    pwr_clr <= 1'b1;
    @(posedge ref_clk_in);
    pwr_clr <= 1'b0;
    rdc(4'h0, 8'h00);
    rdc(4'h2, 8'h0F);
    $display("test power-up clear done");
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    t_reset;
    t_access;
    t_events;
    t_irq;
    t_pwr_clear;
    complete_run;
  end
endmodule // testbench
bind sfr_interrupt_enable_flags sfr_monitor i_mon (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .power_up_clear_in(power_up_clear_in),
  .addr_in(addr_in), .read_in(read_in), .write_in(write_in),
  .wdata_in(wdata_in), .rdata_out(rdata_out),
  .wdt_interval_mode_in(wdt_interval_mode_in),
  .flash_violation_in(flash_violation_in), .wdt_irq_out(wdt_irq_out),
  .nmi_vector_irq_out(nmi_vector_irq_out),
  .flash_violation_irq_out(flash_violation_irq_out));
